// ==== aoc_pkg.sv ====
// package with the register map, field positions, reset values and counts of the activity rate control block
package aoc_pkg;
	// register offsets
	localparam logic [7:0] ADDR_ACTIVITY_THRESHOLD = 8'h1E;
	localparam logic [7:0] ADDR_ACTIVITY_DURATION = 8'h1F;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h20;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h22;
	localparam logic [7:0] ADDR_CONTROL_FIVE = 8'h24;
	localparam logic [7:0] ADDR_OUT_X_LOW = 8'h28;
	localparam logic [7:0] ADDR_OUT_X_HIGH = 8'h29;
	localparam logic [7:0] ADDR_OUT_Y_LOW = 8'h2A;
	localparam logic [7:0] ADDR_OUT_Y_HIGH = 8'h2B;
	localparam logic [7:0] ADDR_OUT_Z_LOW = 8'h2C;
	localparam logic [7:0] ADDR_OUT_Z_HIGH = 8'h2D;
	// field positions
	localparam int RATE_LSB = 4;
	localparam int RATE_MSB = 6;
	localparam int INACT_ROUTE_BIT = 5;
	localparam int SELF_TEST_LSB = 2;
	localparam int SELF_TEST_MSB = 3;
	// values after reset
	localparam logic [7:0] RESET_ACTIVITY_THRESHOLD = 8'h00;
	localparam logic [7:0] RESET_ACTIVITY_DURATION = 8'h00;
	localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RESET_CONTROL_THREE = 8'h00;
	localparam logic [7:0] RESET_CONTROL_FIVE = 8'h00;
	// rate code forced while the device is quiet (10 Hz)
	localparam logic [2:0] RATE_CODE_QUIET = 3'h1;
	// self-test select value that keeps the actuation off
	localparam logic [1:0] SELF_TEST_OFF = 2'h0;
	// trim storage layout: gains x,y,z then offsets x,y,z
	localparam int TRIM_WORDS = 6;
	localparam logic [2:0] TRIM_LAST = 3'h5;
	localparam logic [2:0] TRIM_OFFSET_BASE = 3'h3;
	// unity gain of the sensitivity trim
	localparam logic [7:0] GAIN_UNITY = 8'h80;
	localparam int GAIN_SHIFT = 7;
	// one threshold step is full scale over 128, i.e. 256 counts of a 16-bit sample
	localparam int THRESHOLD_SHIFT = 8;
	// quiet interval is 8 times the duration plus one samples
	localparam int DURATION_SHIFT = 3;
	localparam int HP_SHIFT = 4;
	// boot states
	typedef enum logic [1:0] {
		BOOT_REQ = 2'b00,
		BOOT_CAPTURE = 2'b01,
		BOOT_RUN = 2'b10
	} aoc_boot_t;
endpackage

// ==== aoc_det_if.sv ====
// interface carrying calibrated samples and settings from the core to the inactivity detector
`timescale 1ns/1ps
interface aoc_det_if;
	logic sample_valid; // one-cycle pulse per complete sample set
	logic signed [15:0] sample_x;
	logic signed [15:0] sample_y;
	logic signed [15:0] sample_z;
	logic [7:0] threshold; // activity threshold setting
	logic [7:0] duration; // activity duration setting
	logic inactive; // quiet state reported back
	modport core (output sample_valid, output sample_x, output sample_y, output sample_z, output threshold,
		output duration, input inactive);
	modport det (input sample_valid, input sample_x, input sample_y, input sample_z, input threshold,
		input duration, output inactive);
endinterface

// ==== aoc_inactivity_detect.sv ====
// inactivity detector: high-pass filter, threshold compare and quiet duration counter
`timescale 1ns/1ps
module aoc_inactivity_detect #(
	parameter int COUNT_WIDTH = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	aoc_det_if.det det
);
	// filter baselines, one per axis
	logic signed [15:0] base_reg [3];
	logic signed [15:0] base_next [3];
	// quiet sample counter and state
	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] count_next;
	logic inactive_reg;
	logic inactive_next;
	logic signed [15:0] axis [3];
	logic signed [16:0] hp [3];
	logic [16:0] limit;
	logic [COUNT_WIDTH-1:0] needed;
	logic enable;
	logic exceed;

	// magnitude of a filtered sample
	function automatic logic [16:0] aoc_abs(input logic signed [16:0] v);
		aoc_abs = v[16] ? 17'(-v) : 17'(v);
	endfunction

	assign axis[0] = det.sample_x;
	assign axis[1] = det.sample_y;
	assign axis[2] = det.sample_z;
	assign enable = (det.threshold != 8'h00);
	assign limit = 17'({det.threshold, 8'h00});
	assign needed = COUNT_WIDTH'({det.duration, 3'h0}) + COUNT_WIDTH'(1);
	assign det.inactive = inactive_reg;

	// filter, compare and count
	always_comb begin
		exceed = 1'b0;
		for (int i = 0; i < 3; i++) begin
			hp[i] = 17'(axis[i]) - 17'(base_reg[i]);
			base_next[i] = base_reg[i];
			if (det.sample_valid) begin
				// baseline tracks slowly, filter reseeds while detection is off
				base_next[i] = enable ? 16'(base_reg[i] + 16'(hp[i] >>> aoc_pkg::HP_SHIFT)) : axis[i];
			end
			if (aoc_abs(hp[i]) > limit) begin
				exceed = 1'b1;
			end
		end
		count_next = count_reg;
		inactive_next = inactive_reg;
		if (!enable) begin
			// detection off: always active
			count_next = '0;
			inactive_next = 1'b0;
		end else if (det.sample_valid) begin
			if (exceed) begin
				count_next = '0;
				inactive_next = 1'b0;
			end else begin
				if (count_reg != '1) begin
					count_next = count_reg + COUNT_WIDTH'(1);
				end
				if (count_next >= needed) begin
					inactive_next = 1'b1;
				end
			end
		end
	end

	// register the detector state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				base_reg[i] <= '0;
			end
			count_reg <= '0;
			inactive_reg <= 1'b0;
		end else if (ce) begin
			base_reg <= base_next;
			count_reg <= count_next;
			inactive_reg <= inactive_next;
		end
	end
endmodule

// ==== aoc_activity_odr_control.sv ====
// top of the activity rate control block: registers, trim boot, calibration, data ready and rate override
//
// Notes on behaviour
// - self-test actuation off when select is zero
// - self-test output is acceleration plus test force
// - flag data ready on each new sample set
// - load trim from storage before measuring
// - nonzero threshold enables detection and filter
// - threshold step is full scale over 128
// - quiet long enough forces 10 Hz, field kept
// - exceeding threshold restores programmed rate immediately
// - route inactivity status to interrupt pin one
// - outputs are two's complement, zero is zero
`timescale 1ns/1ps
module aoc_activity_odr_control #(
	parameter int COUNT_WIDTH = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic nvm_rd,
	output logic [2:0] nvm_addr,
	input wire logic [15:0] nvm_rdata,
	input wire logic raw_valid,
	input wire logic signed [15:0] raw_x,
	input wire logic signed [15:0] raw_y,
	input wire logic signed [15:0] raw_z,
	input wire logic signed [15:0] force_x,
	input wire logic signed [15:0] force_y,
	input wire logic signed [15:0] force_z,
	output logic self_test_actuate,
	output logic [1:0] self_test_select,
	output logic [2:0] output_sample_rate,
	output logic boot_done,
	output logic data_ready,
	output logic signed [15:0] accel_x,
	output logic signed [15:0] accel_y,
	output logic signed [15:0] accel_z,
	output logic interrupt_pin_one
);
	// host registers
	logic [7:0] activity_threshold_reg;
	logic [7:0] activity_threshold_next;
	logic [7:0] activity_duration_reg;
	logic [7:0] activity_duration_next;
	logic [7:0] control_one_reg;
	logic [7:0] control_one_next;
	logic [7:0] control_three_reg;
	logic [7:0] control_three_next;
	logic [7:0] control_five_reg;
	logic [7:0] control_five_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	// boot sequencer and trim store
	aoc_pkg::aoc_boot_t boot_reg;
	aoc_pkg::aoc_boot_t boot_next;
	logic [2:0] trim_idx_reg;
	logic [2:0] trim_idx_next;
	logic [15:0] trim_reg [aoc_pkg::TRIM_WORDS];
	logic [15:0] trim_next [aoc_pkg::TRIM_WORDS];
	// sample path
	logic signed [15:0] out_reg [3];
	logic signed [15:0] out_next [3];
	logic valid_reg;
	logic valid_next;
	logic ready_reg;
	logic ready_next;
	logic [2:0] rate_reg;
	logic [2:0] rate_next;
	logic irq_reg;
	logic irq_next;
	logic signed [15:0] raw [3];
	logic signed [15:0] force_in [3];
	logic st_on;
	logic detect_on;

	aoc_det_if det_bus ();

	// gain, test force and offset applied to one axis, saturated to 16 bits
	function automatic logic signed [15:0] aoc_cal(input logic signed [15:0] a, input logic signed [15:0] f,
		input logic st, input logic [7:0] gain, input logic signed [15:0] off);
		logic signed [16:0] sum;
		logic signed [25:0] prod;
		logic signed [25:0] res;
		sum = 17'(a) + (st ? 17'(f) : 17'h00000);
		prod = 26'(sum) * 26'($signed({1'b0, gain}));
		res = (prod >>> aoc_pkg::GAIN_SHIFT) - 26'(off);
		if (res > 26'sh0007FFF) begin
			aoc_cal = 16'sh7FFF;
		end else if (res < -26'sh0008000) begin
			aoc_cal = -16'sh8000;
		end else begin
			aoc_cal = 16'(res);
		end
	endfunction

	assign raw[0] = raw_x;
	assign raw[1] = raw_y;
	assign raw[2] = raw_z;
	assign force_in[0] = force_x;
	assign force_in[1] = force_y;
	assign force_in[2] = force_z;
	assign self_test_select = control_five_reg[aoc_pkg::SELF_TEST_MSB:aoc_pkg::SELF_TEST_LSB];
	assign st_on = (self_test_select != aoc_pkg::SELF_TEST_OFF);
	assign self_test_actuate = st_on;
	assign detect_on = (activity_threshold_reg != 8'h00);
	assign reg_rdata = rdata_reg;
	assign nvm_rd = (boot_reg == aoc_pkg::BOOT_REQ);
	assign nvm_addr = trim_idx_reg;
	assign boot_done = (boot_reg == aoc_pkg::BOOT_RUN);
	assign data_ready = ready_reg;
	assign accel_x = out_reg[0];
	assign accel_y = out_reg[1];
	assign accel_z = out_reg[2];
	assign output_sample_rate = rate_reg;
	assign interrupt_pin_one = irq_reg;

	// settings and samples toward the detector
	assign det_bus.sample_valid = valid_reg;
	assign det_bus.sample_x = out_reg[0];
	assign det_bus.sample_y = out_reg[1];
	assign det_bus.sample_z = out_reg[2];
	assign det_bus.threshold = activity_threshold_reg;
	assign det_bus.duration = activity_duration_reg;

	// quiet state detector
	aoc_inactivity_detect #(
		.COUNT_WIDTH(COUNT_WIDTH)
	) u_detect (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.det(det_bus)
	);

	// register writes and read data
	always_comb begin
		activity_threshold_next = activity_threshold_reg;
		activity_duration_next = activity_duration_reg;
		control_one_next = control_one_reg;
		control_three_next = control_three_reg;
		control_five_next = control_five_reg;
		rdata_next = rdata_reg;
		if (reg_wr) begin
			case (reg_addr)
				aoc_pkg::ADDR_ACTIVITY_THRESHOLD: begin
					activity_threshold_next = reg_wdata;
				end
				aoc_pkg::ADDR_ACTIVITY_DURATION: begin
					activity_duration_next = reg_wdata;
				end
				aoc_pkg::ADDR_CONTROL_ONE: begin
					control_one_next = reg_wdata;
				end
				aoc_pkg::ADDR_CONTROL_THREE: begin
					control_three_next = reg_wdata;
				end
				aoc_pkg::ADDR_CONTROL_FIVE: begin
					control_five_next = reg_wdata;
				end
				default: begin
					// writes elsewhere are ignored
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				aoc_pkg::ADDR_ACTIVITY_THRESHOLD: rdata_next = activity_threshold_reg;
				aoc_pkg::ADDR_ACTIVITY_DURATION: rdata_next = activity_duration_reg;
				aoc_pkg::ADDR_CONTROL_ONE: rdata_next = control_one_reg; // stored rate field stays untouched
				aoc_pkg::ADDR_CONTROL_THREE: rdata_next = control_three_reg;
				aoc_pkg::ADDR_CONTROL_FIVE: rdata_next = control_five_reg;
				aoc_pkg::ADDR_OUT_X_LOW: rdata_next = out_reg[0][7:0];
				aoc_pkg::ADDR_OUT_X_HIGH: rdata_next = out_reg[0][15:8];
				aoc_pkg::ADDR_OUT_Y_LOW: rdata_next = out_reg[1][7:0];
				aoc_pkg::ADDR_OUT_Y_HIGH: rdata_next = out_reg[1][15:8];
				aoc_pkg::ADDR_OUT_Z_LOW: rdata_next = out_reg[2][7:0];
				aoc_pkg::ADDR_OUT_Z_HIGH: rdata_next = out_reg[2][15:8];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// boot: read each trim word, then start measuring
	always_comb begin
		boot_next = boot_reg;
		trim_idx_next = trim_idx_reg;
		trim_next = trim_reg;
		case (boot_reg)
			aoc_pkg::BOOT_REQ: begin
				boot_next = aoc_pkg::BOOT_CAPTURE;
			end
			aoc_pkg::BOOT_CAPTURE: begin
				trim_next[trim_idx_reg] = nvm_rdata;
				if (trim_idx_reg == aoc_pkg::TRIM_LAST) begin
					boot_next = aoc_pkg::BOOT_RUN;
				end else begin
					trim_idx_next = trim_idx_reg + 3'h1;
					boot_next = aoc_pkg::BOOT_REQ;
				end
			end
			aoc_pkg::BOOT_RUN: begin
				// trims stay fixed while measuring
			end
			default: begin
				boot_next = aoc_pkg::BOOT_REQ;
				trim_idx_next = 3'h0;
			end
		endcase
	end

	// calibration, data ready, effective rate and interrupt pin
	always_comb begin
		out_next = out_reg;
		valid_next = 1'b0;
		ready_next = ready_reg;
		// reading the last output byte consumes the set
		if (reg_rd && reg_addr == aoc_pkg::ADDR_OUT_Z_HIGH) begin
			ready_next = 1'b0;
		end
		if (raw_valid && boot_reg == aoc_pkg::BOOT_RUN) begin
			for (int i = 0; i < 3; i++) begin
				out_next[i] = aoc_cal(raw[i], force_in[i], st_on, trim_reg[i][7:0],
					trim_reg[int'(aoc_pkg::TRIM_OFFSET_BASE) + i]);
			end
			valid_next = 1'b1;
			ready_next = 1'b1;
		end
		// quiet override or programmed rate
		rate_next = det_bus.inactive ? aoc_pkg::RATE_CODE_QUIET
			: control_one_reg[aoc_pkg::RATE_MSB:aoc_pkg::RATE_LSB];
		irq_next = detect_on && control_three_reg[aoc_pkg::INACT_ROUTE_BIT] && det_bus.inactive;
	end

	// register all state of the top
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			activity_threshold_reg <= aoc_pkg::RESET_ACTIVITY_THRESHOLD;
			activity_duration_reg <= aoc_pkg::RESET_ACTIVITY_DURATION;
			control_one_reg <= aoc_pkg::RESET_CONTROL_ONE;
			control_three_reg <= aoc_pkg::RESET_CONTROL_THREE;
			control_five_reg <= aoc_pkg::RESET_CONTROL_FIVE;
			rdata_reg <= 8'h00;
			boot_reg <= aoc_pkg::BOOT_REQ;
			trim_idx_reg <= 3'h0;
			for (int i = 0; i < aoc_pkg::TRIM_WORDS; i++) begin
				trim_reg[i] <= 16'h0000;
			end
			for (int i = 0; i < 3; i++) begin
				out_reg[i] <= 16'sh0000;
			end
			valid_reg <= 1'b0;
			ready_reg <= 1'b0;
			rate_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else if (ce) begin
			activity_threshold_reg <= activity_threshold_next;
			activity_duration_reg <= activity_duration_next;
			control_one_reg <= control_one_next;
			control_three_reg <= control_three_next;
			control_five_reg <= control_five_next;
			rdata_reg <= rdata_next;
			boot_reg <= boot_next;
			trim_idx_reg <= trim_idx_next;
			trim_reg <= trim_next;
			out_reg <= out_next;
			valid_reg <= valid_next;
			ready_reg <= ready_next;
			rate_reg <= rate_next;
			irq_reg <= irq_next;
		end
	end
endmodule

// ==== aoc_trim_store.sv ====
// model of the trim storage that answers the block's boot reads
`timescale 1ns/1ps
module aoc_trim_store (
	input wire logic clk,
	input wire logic nvm_rd,
	input wire logic [2:0] nvm_addr,
	output logic [15:0] nvm_rdata
);
	// gains x,y,z at unity, then offsets x,y,z
	logic [15:0] trim_mem [6] = '{16'h0080, 16'h0080, 16'h0080, 16'h0010, 16'h0000, 16'h0000};
	logic [15:0] data_reg = 16'h5A5A; // line value
	// word shows the cycle after a request, otherwise the line toggles
	always @(posedge clk) begin
		if (nvm_rd) begin
			data_reg <= trim_mem[nvm_addr];
		end else begin
			data_reg <= ~data_reg;
		end
	end
	assign nvm_rdata = data_reg;
endmodule

// ==== aoc_activity_odr_control_checker.sv ====
// assertions on the ports of the activity rate control block
`timescale 1ns/1ps
module aoc_activity_odr_control_checker #(
	parameter int COUNT_WIDTH = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic raw_valid,
	input wire logic nvm_rd,
	input wire logic [2:0] nvm_addr,
	input wire logic self_test_actuate,
	input wire logic [1:0] self_test_select,
	input wire logic [2:0] output_sample_rate,
	input wire logic boot_done,
	input wire logic data_ready,
	input wire logic signed [15:0] accel_x,
	input wire logic interrupt_pin_one
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ST_OFF: assert property ((self_test_select == aoc_pkg::SELF_TEST_OFF) |-> !self_test_actuate)
		else $error("self-test on while select is zero");
	AST_ST_ON: assert property ((self_test_select != aoc_pkg::SELF_TEST_OFF) |-> self_test_actuate)
		else $error("self-test off while selected");
	AST_READY_SET: assert property (raw_valid && ce && boot_done |=> data_ready)
		else $error("no data ready after sample");
	AST_ACCEL_HOLD: assert property (!(raw_valid && ce && boot_done) |=> $stable(accel_x))
		else $error("output changed without sample");
	AST_PRE_BOOT: assert property (!boot_done |-> !data_ready)
		else $error("data ready before boot");
	AST_BOOT_HOLD: assert property (boot_done |=> boot_done)
		else $error("boot done dropped");
	AST_NVM_PAIR: assert property (nvm_rd && ce |=> !nvm_rd)
		else $error("trim request not paired");
	AST_NVM_RANGE: assert property (nvm_rd |-> nvm_addr <= aoc_pkg::TRIM_LAST)
		else $error("trim index out of range");
	AST_IRQ_QUIET: assert property (interrupt_pin_one |-> output_sample_rate == aoc_pkg::RATE_CODE_QUIET)
		else $error("pin one high while rate not quiet");
	// main scenarios
	cover property (interrupt_pin_one);
	cover property (self_test_actuate);
	cover property ($fell(data_ready));
endmodule
bind aoc_activity_odr_control aoc_activity_odr_control_checker #(.COUNT_WIDTH(COUNT_WIDTH)) chk_u (
	.clk(clk), .rst(rst), .ce(ce), .raw_valid(raw_valid), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
	.self_test_actuate(self_test_actuate), .self_test_select(self_test_select),
	.output_sample_rate(output_sample_rate), .boot_done(boot_done), .data_ready(data_ready),
	.accel_x(accel_x), .interrupt_pin_one(interrupt_pin_one));

// ==== aoc_activity_odr_control_bench.sv ====
// self-checking bench for the activity rate control block
`timescale 1ns/1ps
module aoc_activity_odr_control_bench;
	typedef struct packed {logic [1:0] sel; logic [15:0] rx; logic [15:0] ry;
		logic [15:0] ex; logic [15:0] ey;} aoc_row_t;
	logic clk, rst, ce, reg_wr, reg_rd, raw_valid, nvm_rd, self_test_actuate, boot_done, data_ready, interrupt_pin_one;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] nvm_addr, output_sample_rate;
	logic [1:0] self_test_select;
	logic [15:0] nvm_rdata, raw_x, raw_y, raw_z, force_x, force_y, force_z, accel_x, accel_y, accel_z;
	int error_cnt = 0; // mismatches
	int n_compared = 0; // comparisons
	int cyc = 0; // cycle count for the timeout
	// self-test select, raw x/y, expected x/y (force 100/-20, x offset 16)
	aoc_row_t rows [4] = '{'{2'h0, 16'h03E8, 16'h0000, 16'h03D8, 16'h0000},
		'{2'h1, 16'h03E8, 16'h0005, 16'h043C, 16'hFFF1}, '{2'h2, 16'hFFCE, 16'hFFF6, 16'h0022, 16'hFFE2},
		'{2'h3, 16'h0000, 16'h0014, 16'h0054, 16'h0000}};
	logic [7:0] regs [5] = '{aoc_pkg::ADDR_ACTIVITY_THRESHOLD, aoc_pkg::ADDR_ACTIVITY_DURATION,
		aoc_pkg::ADDR_CONTROL_ONE, aoc_pkg::ADDR_CONTROL_THREE, aoc_pkg::ADDR_CONTROL_FIVE};
	aoc_activity_odr_control dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
		.nvm_rdata(nvm_rdata), .raw_valid(raw_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.force_x(force_x), .force_y(force_y), .force_z(force_z), .self_test_actuate(self_test_actuate),
		.self_test_select(self_test_select), .output_sample_rate(output_sample_rate), .boot_done(boot_done),
		.data_ready(data_ready), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
		.interrupt_pin_one(interrupt_pin_one));
	aoc_trim_store trim_u (.clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		step();
		reg_wr = 1'b0;
		repeat (2) step();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'b1;
		reg_addr = a;
		step();
		reg_rd = 1'b0;
		chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
		step();
	endtask
	// one sample set, then time for detector and rate to follow
	task automatic smp(input logic [15:0] x, input logic [15:0] y);
		raw_valid = 1'b1;
		raw_x = x;
		raw_y = y;
		step();
		raw_valid = 1'b0;
		raw_x = ~x;
		repeat (4) step();
	endtask
	task automatic chk_rate(input logic [2:0] r, input logic q);
		chk("output_sample_rate", {13'h0, r}, {13'h0, output_sample_rate});
		chk("interrupt_pin_one", {15'h0, q}, {15'h0, interrupt_pin_one});
	endtask
	task automatic boot();
		for (int i = 0; i < 40 && boot_done !== 1'b1; i++) step();
		chk("boot_done", 16'h0001, {15'h0, boot_done});
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{reg_wr, reg_rd, raw_valid, reg_addr, reg_wdata, raw_x, raw_y, raw_z, force_z} = '0;
		force_x = 16'h0064;
		force_y = 16'hFFEC;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		boot();
		foreach (rows[i]) begin
			wr(aoc_pkg::ADDR_CONTROL_FIVE, {4'h0, rows[i].sel, 2'h0});
			chk("self_test_actuate", {15'h0, rows[i].sel != 2'h0}, {15'h0, self_test_actuate});
			chk("self_test_select", {14'h0, rows[i].sel}, {14'h0, self_test_select});
			smp(rows[i].rx, rows[i].ry);
			chk("accel_x", rows[i].ex, accel_x);
			chk("accel_y", rows[i].ey, accel_y);
			chk("accel_z", 16'h0000, accel_z);
			chk("data_ready", 16'h0001, {15'h0, data_ready});
			rd(aoc_pkg::ADDR_OUT_X_LOW, rows[i].ex[7:0]);
			rd(aoc_pkg::ADDR_OUT_Y_HIGH, rows[i].ey[15:8]);
			rd(aoc_pkg::ADDR_OUT_Z_HIGH, 8'h00);
			chk("data_ready", 16'h0000, {15'h0, data_ready});
		end
		// second reset mid-run, samples before boot ignored
		rst = 1'b1;
		step();
		rst = 1'b0;
		smp(16'h0100, 16'h0000);
		chk("data_ready", 16'h0000, {15'h0, data_ready});
		boot();
		for (int i = 0; i < 5; i++) begin
			rd(regs[i], 8'h00);
			wr(regs[i], 8'hA5);
			rd(regs[i], 8'hA5);
			wr(regs[i], 8'h00);
		end
		rd(8'h23, 8'h00);
		wr(aoc_pkg::ADDR_OUT_X_LOW, 8'h77);
		rd(aoc_pkg::ADDR_OUT_X_LOW, 8'h00);
		// quiet interval, threshold boundary, wake and re-arm
		smp(16'h0000, 16'h0000);
		wr(aoc_pkg::ADDR_CONTROL_ONE, 8'h60);
		// first sample after the rate change is taken in like any other and left unread
		smp(16'h0000, 16'h0000);
		wr(aoc_pkg::ADDR_ACTIVITY_DURATION, 8'h01);
		wr(aoc_pkg::ADDR_CONTROL_THREE, 8'h20);
		wr(aoc_pkg::ADDR_ACTIVITY_THRESHOLD, 8'h01);
		chk_rate(3'h6, 1'b0);
		smp(16'h0100, 16'h0000);
		repeat (7) smp(16'h0000, 16'h0000);
		chk_rate(3'h6, 1'b0);
		smp(16'h0000, 16'h0000);
		chk_rate(3'h1, 1'b1);
		rd(aoc_pkg::ADDR_CONTROL_ONE, 8'h60);
		smp(16'h03E8, 16'h0000);
		chk_rate(3'h6, 1'b0);
		repeat (8) smp(16'h0000, 16'h0000);
		chk_rate(3'h6, 1'b0);
		smp(16'h0000, 16'h0000);
		chk_rate(3'h1, 1'b1);
		wr(aoc_pkg::ADDR_CONTROL_THREE, 8'h00);
		chk_rate(3'h1, 1'b0);
		wr(aoc_pkg::ADDR_ACTIVITY_THRESHOLD, 8'h00);
		chk_rate(3'h6, 1'b0);
		// clock enable low: a sample and a rate write are both held off
		ce = 1'b0;
		smp(16'h03E8, 16'h0000);
		wr(aoc_pkg::ADDR_CONTROL_ONE, 8'h30);
		ce = 1'b1;
		repeat (2) step();
		chk("accel_x", 16'hFFF0, accel_x);
		chk_rate(3'h6, 1'b0);
		end_sim();
	end
endmodule
